// >>> hdl/sfh_flash_front.sv
/*
  Serial flash front end: link-side transaction framing on serial_clock,
  command memory, program/erase engine and ECC-protected array on sys_clk.
  Assumes a host in clock mode 0 or 3, chip select idle high, and straps
  page_512 / large_sector that change only while the device is idle.
*/
`timescale 1ns/1ps
`default_nettype none

module sfh_flash_front #(
  parameter int AW = 12
) (
  // System clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Serial link
  input  wire logic       serial_clock,
  input  wire logic       cs_n,
  input  wire logic       reset_n,
  input  wire logic [3:0] dq_in,
  output logic      [3:0] dq_out,
  output logic      [3:0] dq_oe_n,
  // Configuration straps
  input  wire logic       page_512,
  input  wire logic       large_sector,
  // Status
  output logic            ready
);
  import sfh_pkg::*;

  localparam int ARRAY_BYTES = 1 << AW;
  localparam int ER_SMALL    = (SECT_SMALL < ARRAY_BYTES) ? SECT_SMALL : ARRAY_BYTES;
  localparam int ER_LARGE    = (SECT_LARGE < ARRAY_BYTES) ? SECT_LARGE : ARRAY_BYTES;

  // Resets: pin reset kills all link-side state, chip select ends the frame
  wire dev_rst   = sys_rst | ~reset_n;
  wire frame_rst = dev_rst | cs_n;

  // Link domain, frame state
  sfh_phase_e  ph_q;
  logic [5:0]  cnt_q;
  logic [31:0] sh_q;
  logic [7:0]  cmd_q;
  sfh_attr_s   attr_q;
  logic [31:0] addr_q;
  logic [31:0] word_q;

  // Link domain, survives frames
  logic        hdr_tgl_q;
  logic        dat_tgl_q;
  logic        rdq_tgl_q;
  sfh_hdr_s    hdr_hold_q;
  logic [7:0]  dat_hold_q;
  logic [31:0] rd_addr_q;
  sfh_stat_s   st_s1_q;
  sfh_stat_s   st_s2_q;
  logic        ack_s1_q;
  logic        ack_s2_q;
  logic        ack_seen_q;
  logic [31:0] pend_q;

  // System domain
  logic [6:0]  sy_s1_q;
  logic [6:0]  sy_s2_q;
  logic [3:0]  sy_prev_q;
  sfh_hdr_s    cur_hdr_q;
  logic        have_cmd_q;
  logic [9:0]  buf_cnt_q;
  sfh_eng_e    eng_q;
  logic [16:0] step_q;
  logic [31:0] base_q;
  logic        susp_q;
  logic        addr4_q;
  logic        ecc_fix_q;
  logic        ecc_bad_q;
  logic [31:0] rd_word_q;
  logic        ack_tgl_q;
  sfh_stat_s   stat_q;
  logic        ready_q;
  logic [CW_W-1:0] mem [0:ARRAY_BYTES-1];
  logic [7:0]      pbuf [0:PAGE_LARGE-1];

  // Link-side decode
  wire         rd_block  = st_s2_q.busy & ~st_s2_q.susp;
  wire         lane4     = (ph_q == PH_ADDR) ? attr_q.quad_addr : attr_q.quad_data;
  wire [31:0]  sh_nx     = lane4 ? {sh_q[27:0], dq_in} : {sh_q[30:0], dq_in[0]};
  sfh_attr_s   cmd_attr;
  assign cmd_attr = sfh_cmd_decode(sh_nx[7:0], rd_block);
  wire [5:0]   addr_cyc  = 6'((st_s2_q.addr4 ? ADDR4_BITS : ADDR3_BITS)
                              / (attr_q.quad_addr ? QUAD_W : 1));
  wire         cmd_done  = (ph_q == PH_CMD) && (cnt_q == 6'(CMD_BITS - 1));
  wire         addr_done = (ph_q == PH_ADDR) && (cnt_q == addr_cyc - 6'd1);
  wire         lat_done  = (ph_q == PH_LAT) && (cnt_q == 6'(LAT_CYCLES - 1));
  wire         din_byte  = (ph_q == PH_DIN) &&
                           (cnt_q == (attr_q.quad_data ? 6'd1 : 6'd7));
  wire         unit_end  = (ph_q == PH_DOUT) &&
                           (cnt_q == ((attr_q.rd_status | attr_q.quad_data) ? 6'd7 : 6'd31));
  wire         dout_unit = unit_end & attr_q.rd_array;
  wire [31:0]  addr_nx   = addr_done ? sh_nx : addr_q + 32'(WORD_BYTES);
  wire [7:0]   st1_b     = {5'h00, st_s2_q.addr4, st_s2_q.susp, st_s2_q.busy};
  wire [7:0]   st2_b     = {6'h00, st_s2_q.ecc_bad, st_s2_q.ecc_fix};
  wire [7:0]   cmd_st_b  = cmd_attr.st2 ? st2_b : st1_b;
  wire [7:0]   st_b      = attr_q.st2 ? st2_b : st1_b;
  wire [31:0]  load_word = attr_q.rd_status ? {st_b, 24'h000000} : pend_q;
  wire         hdr_fire  = (cmd_done & ~cmd_attr.has_addr) | addr_done;
  sfh_hdr_s    hdr_val;
  assign hdr_val = addr_done ? {cmd_q, sh_nx} : {sh_nx[7:0], 32'h00000000};
  wire         rdq_fire  = (addr_done & attr_q.rd_array) | lat_done | dout_unit;

  // Phase sequencing
  sfh_phase_e  ph_d;
  assign ph_d = cmd_done ? (cmd_attr.has_addr ? PH_ADDR :
                            cmd_attr.rd_status ? PH_DOUT : PH_IGN)
              : addr_done ? (attr_q.rd_array ? PH_LAT :
                             attr_q.wr_data ? PH_DIN : PH_IGN)
              : lat_done ? PH_DOUT : ph_q;
  wire         cnt_clr = cmd_done | addr_done | lat_done | din_byte | unit_end;
  wire [5:0]   cnt_d   = cnt_clr ? 6'd0 : (ph_q == PH_IGN) ? cnt_q : cnt_q + 6'd1;
  wire [31:0]  word_sh = attr_q.quad_data ? {word_q[27:0], 4'h0} : {word_q[30:0], 1'b0};
  wire [31:0]  word_d  = cmd_done ? {cmd_st_b, 24'h000000}
                       : (lat_done | unit_end) ? load_word
                       : (ph_q == PH_DOUT) ? word_sh : word_q;

  // Capture on rising edges; frame state dies with chip select
  always_ff @(posedge serial_clock or posedge frame_rst) begin
    if (frame_rst) begin
      ph_q   <= PH_CMD;
      cnt_q  <= '0;
      sh_q   <= '0;
      cmd_q  <= '0;
      attr_q <= '0;
      addr_q <= '0;
      word_q <= '0;
    end else begin
      ph_q   <= ph_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_nx;
      word_q <= word_d;
      if (cmd_done) begin
        cmd_q  <= sh_nx[7:0];
        attr_q <= cmd_attr;
      end
      if (addr_done | lat_done | dout_unit) addr_q <= addr_nx;
    end
  end

  // Drive on falling edges; quiet unless in a data-out phase
  always_ff @(negedge serial_clock or posedge frame_rst) begin
    if (frame_rst) begin
      dq_out  <= 4'h0;
      dq_oe_n <= 4'hF;
    end else if (ph_q == PH_DOUT && attr_q.quad_data) begin
      dq_out  <= word_q[31:28];
      dq_oe_n <= 4'h0;
    end else if (ph_q == PH_DOUT) begin
      dq_out  <= {2'b00, word_q[31], 1'b0};
      dq_oe_n <= 4'hD;
    end else begin
      dq_out  <= 4'h0;
      dq_oe_n <= 4'hF;
    end
  end

  // Toggles must not reset on chip select, or a frame end fakes an event
  always_ff @(posedge serial_clock or posedge dev_rst) begin
    if (dev_rst) begin
      hdr_tgl_q  <= 1'b0;
      dat_tgl_q  <= 1'b0;
      rdq_tgl_q  <= 1'b0;
      hdr_hold_q <= '0;
      dat_hold_q <= '0;
      rd_addr_q  <= '0;
    end else begin
      if (hdr_fire) begin
        hdr_hold_q <= hdr_val;
        hdr_tgl_q  <= ~hdr_tgl_q;
      end
      if (din_byte) begin
        dat_hold_q <= sh_nx[7:0];
        dat_tgl_q  <= ~dat_tgl_q;
      end
      if (rdq_fire) begin
        rd_addr_q <= addr_nx;
        rdq_tgl_q <= ~rdq_tgl_q;
      end
    end
  end

  // Status and read-word return into the link domain
  always_ff @(posedge serial_clock or posedge dev_rst) begin
    if (dev_rst) begin
      st_s1_q    <= '0;
      st_s2_q    <= '0;
      ack_s1_q   <= 1'b0;
      ack_s2_q   <= 1'b0;
      ack_seen_q <= 1'b0;
      pend_q     <= '0;
    end else begin
      st_s1_q    <= stat_q;
      st_s2_q    <= st_s1_q;
      ack_s1_q   <= ack_tgl_q;
      ack_s2_q   <= ack_s1_q;
      ack_seen_q <= ack_s2_q;
      if (ack_s2_q != ack_seen_q) pend_q <= rd_word_q;
    end
  end

  // System-side synchronisers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sy_s1_q   <= SYNC_RST;
      sy_s2_q   <= SYNC_RST;
      sy_prev_q <= 4'h8;
    end else begin
      sy_s1_q   <= {cs_n, reset_n, page_512, large_sector, hdr_tgl_q, dat_tgl_q, rdq_tgl_q};
      sy_s2_q   <= sy_s1_q;
      sy_prev_q <= {sy_s2_q[6], sy_s2_q[2:0]};
    end
  end

  wire         soft_rst = ~sy_s2_q[5];
  wire         page_big = sy_s2_q[4];
  wire         sect_big = sy_s2_q[3];
  wire         cs_rise  = sy_s2_q[6] & ~sy_prev_q[3] & ~soft_rst;
  wire         hdr_ev   = (sy_s2_q[2] ^ sy_prev_q[2]) & ~soft_rst;
  wire         dat_ev   = (sy_s2_q[1] ^ sy_prev_q[1]) & ~soft_rst;
  wire         rdq_ev   = (sy_s2_q[0] ^ sy_prev_q[0]) & ~soft_rst;
  wire         busy     = eng_q != EN_IDLE;
  wire         run      = busy & ~susp_q;
  wire         is_prog  = cur_hdr_q.cmd == CMD_PROG || cur_hdr_q.cmd == CMD_QPROG;
  wire [9:0]   page_sz  = page_big ? 10'(PAGE_LARGE) : 10'(PAGE_SMALL);
  wire [31:0]  page_msk = page_big ? 32'(PAGE_LARGE - 1) : 32'(PAGE_SMALL - 1);
  wire [31:0]  sect_msk = sect_big ? 32'(SECT_LARGE - 1) : 32'(SECT_SMALL - 1);
  wire [16:0]  er_last  = sect_big ? 17'(ER_LARGE - 1) : 17'(ER_SMALL - 1);
  wire [31:0]  prog_tgt = (base_q & ~page_msk) | ((base_q + 32'(step_q)) & page_msk);
  wire [31:0]  er_tgt   = (base_q & ~sect_msk) + 32'(step_q);
  wire         commit   = cs_rise & have_cmd_q;
  wire         wr_prog  = run && eng_q == EN_PROG;
  wire [AW-1:0] mem_wa  = wr_prog ? prog_tgt[AW-1:0] : er_tgt[AW-1:0];
  sfh_ecc_s    old_dec;
  assign old_dec = sfh_ecc_dec(mem[mem_wa]);
  wire [7:0]   prog_b   = old_dec.data & pbuf[step_q[8:0]];
  wire [CW_W-1:0] mem_wd = wr_prog ? sfh_ecc_enc(prog_b) : ERASED_CW;
  wire         last_stp = wr_prog ? (step_q + 17'd1 == 17'(buf_cnt_q)) : (step_q == er_last);

  sfh_ecc_s    rd_dec [0:WORD_BYTES-1];
  for (genvar i = 0; i < WORD_BYTES; i++) begin : g_rd
    assign rd_dec[i] = sfh_ecc_dec(mem[AW'(rd_addr_q + 32'(i))]);
  end
  wire         any_sgl = rd_dec[0].sgl | rd_dec[1].sgl | rd_dec[2].sgl | rd_dec[3].sgl;
  wire         any_dbl = rd_dec[0].dbl | rd_dec[1].dbl | rd_dec[2].dbl | rd_dec[3].dbl;

  // Command memory: header and page data of the current frame
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_hdr_q  <= '0;
      have_cmd_q <= 1'b0;
      buf_cnt_q  <= '0;
    end else if (soft_rst) begin
      have_cmd_q <= 1'b0;
      buf_cnt_q  <= '0;
    end else begin
      if (cs_rise) have_cmd_q <= 1'b0;
      if (hdr_ev) begin
        cur_hdr_q  <= hdr_hold_q;
        have_cmd_q <= 1'b1;
        buf_cnt_q  <= '0;
      end else if (dat_ev && is_prog && !busy && buf_cnt_q < page_sz) begin
        buf_cnt_q <= buf_cnt_q + 10'd1;
      end
    end
  end

  // Bytes past one page are dropped rather than wrapped
  always_ff @(posedge sys_clk) begin
    if (dat_ev && is_prog && !busy && buf_cnt_q < page_sz) pbuf[buf_cnt_q[8:0]] <= dat_hold_q;
  end

  always_ff @(posedge sys_clk) begin
    if (run) mem[mem_wa] <= mem_wd;
  end

  // Algorithm engine
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      eng_q   <= EN_IDLE;
      step_q  <= '0;
      base_q  <= '0;
      susp_q  <= 1'b0;
      addr4_q <= 1'b0;
    end else if (soft_rst) begin
      eng_q   <= EN_IDLE;
      step_q  <= '0;
      susp_q  <= 1'b0;
      addr4_q <= 1'b0;
    end else if (commit && busy) begin
      if (cur_hdr_q.cmd == CMD_SUSPEND) susp_q <= 1'b1;
      if (cur_hdr_q.cmd == CMD_RESUME) susp_q <= 1'b0;
    end else if (commit) begin
      step_q <= '0;
      base_q <= cur_hdr_q.addr;
      if (is_prog && buf_cnt_q != 10'd0) eng_q <= EN_PROG;
      if (cur_hdr_q.cmd == CMD_ERASE) eng_q <= EN_ERASE;
      if (cur_hdr_q.cmd == CMD_EN_ADDR4) addr4_q <= 1'b1;
      if (cur_hdr_q.cmd == CMD_EX_ADDR4) addr4_q <= 1'b0;
    end else if (run) begin
      step_q <= step_q + 17'd1;
      if (last_stp) eng_q <= EN_IDLE;
    end
  end

  // Array read for the link; ECC flags set wins over clear
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_word_q <= '0;
      ack_tgl_q <= 1'b0;
      ecc_fix_q <= 1'b0;
      ecc_bad_q <= 1'b0;
    end else begin
      if (soft_rst || (commit && cur_hdr_q.cmd == CMD_RD_ST2)) begin
        ecc_fix_q <= 1'b0;
        ecc_bad_q <= 1'b0;
      end
      if (rdq_ev) begin
        rd_word_q <= {rd_dec[0].data, rd_dec[1].data, rd_dec[2].data, rd_dec[3].data};
        ack_tgl_q <= ~ack_tgl_q;
        if (any_sgl) ecc_fix_q <= 1'b1;
        if (any_dbl) ecc_bad_q <= 1'b1;
      end
    end
  end

  // Status levels toward the link, and the ready pin
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_q  <= '0;
      ready_q <= 1'b1;
    end else begin
      stat_q  <= '{ecc_bad: ecc_bad_q, ecc_fix: ecc_fix_q, addr4: addr4_q,
                   susp: susp_q, busy: busy};
      ready_q <= ~busy;
    end
  end

  assign ready = ready_q;

endmodule : sfh_flash_front

`default_nettype wire

// >>> hdl/sfh_pkg.sv
/*
  Shared constants, carriers and functions of the serial flash front end.
  Assumes two importers: sfh_flash_front, with a byte-wide ECC-protected array, and serial_flash_host_interface_test.
*/
package sfh_pkg;

  // Command codes
  localparam logic [7:0] CMD_READ      = 8'h03;
  localparam logic [7:0] CMD_FAST_READ = 8'h0B;
  localparam logic [7:0] CMD_QOUT_READ = 8'h6B;
  localparam logic [7:0] CMD_QIO_READ  = 8'hEB;
  localparam logic [7:0] CMD_PROG      = 8'h02;
  localparam logic [7:0] CMD_QPROG     = 8'h32;
  localparam logic [7:0] CMD_ERASE     = 8'hD8;
  localparam logic [7:0] CMD_RD_ST1    = 8'h05;
  localparam logic [7:0] CMD_RD_ST2    = 8'h07;
  localparam logic [7:0] CMD_SUSPEND   = 8'h75;
  localparam logic [7:0] CMD_RESUME    = 8'h7A;
  localparam logic [7:0] CMD_EN_ADDR4  = 8'hB7;
  localparam logic [7:0] CMD_EX_ADDR4  = 8'hE9;

  // Framing and sizes
  localparam int CMD_BITS    = 8;
  localparam int ADDR3_BITS  = 24;
  localparam int ADDR4_BITS  = 32;
  localparam int QUAD_W      = 4;
  localparam int LAT_CYCLES  = 8;
  localparam int WORD_BYTES  = 4;
  localparam int PAGE_SMALL  = 256;
  localparam int PAGE_LARGE  = 512;
  localparam int SECT_SMALL  = 65536;
  localparam int SECT_LARGE  = 131072;
  localparam int CW_W        = 13;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [6:0] SYNC_RST    = 7'h60;

  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_LAT, PH_DIN, PH_DOUT, PH_IGN} sfh_phase_e;
  typedef enum logic [1:0] {EN_IDLE, EN_PROG, EN_ERASE} sfh_eng_e;

  typedef struct packed {
    logic has_addr;
    logic quad_addr;
    logic quad_data;
    logic rd_array;
    logic rd_status;
    logic st2;
    logic wr_data;
  } sfh_attr_s;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [31:0] addr;
  } sfh_hdr_s;

  typedef struct packed {
    logic ecc_bad;
    logic ecc_fix;
    logic addr4;
    logic susp;
    logic busy;
  } sfh_stat_s;

  typedef struct packed {
    logic       dbl;
    logic       sgl;
    logic [7:0] data;
  } sfh_ecc_s;

  // Array reads are dropped while an algorithm runs unsuspended
  function automatic sfh_attr_s sfh_cmd_decode(input logic [7:0] cmd, input logic rd_block);
    sfh_attr_s a;
    a = '0;
    case (cmd)
      CMD_READ, CMD_FAST_READ: begin
        a.has_addr = 1'b1;
        a.rd_array = ~rd_block;
      end
      CMD_QOUT_READ: begin
        a.has_addr  = 1'b1;
        a.quad_data = 1'b1;
        a.rd_array  = ~rd_block;
      end
      CMD_QIO_READ: begin
        a.has_addr  = 1'b1;
        a.quad_addr = 1'b1;
        a.quad_data = 1'b1;
        a.rd_array  = ~rd_block;
      end
      CMD_PROG: begin
        a.has_addr = 1'b1;
        a.wr_data  = 1'b1;
      end
      CMD_QPROG: begin
        a.has_addr  = 1'b1;
        a.quad_data = 1'b1;
        a.wr_data   = 1'b1;
      end
      CMD_ERASE:  a.has_addr = 1'b1;
      CMD_RD_ST1: a.rd_status = 1'b1;
      CMD_RD_ST2: begin
        a.rd_status = 1'b1;
        a.st2       = 1'b1;
      end
      default: a = '0;
    endcase
    return a;
  endfunction : sfh_cmd_decode

  // Hamming positions 1..12, checks at 1,2,4,8, overall parity at bit 0
  function automatic logic [12:0] sfh_ecc_enc(input logic [7:0] d);
    logic [12:0] c;
    int          j;
    c = '0;
    j = 0;
    for (int p = 3; p < 13; p++) begin
      if (p != 4 && p != 8) begin
        c[p] = d[j];
        j++;
      end
    end
    for (int k = 0; k < 4; k++) begin
      for (int p = 3; p < 13; p++) begin
        if (p != 4 && p != 8 && p[k]) c[1 << k] = c[1 << k] ^ c[p];
      end
    end
    c[0] = ^c[12:1];
    return c;
  endfunction : sfh_ecc_enc

  function automatic sfh_ecc_s sfh_ecc_dec(input logic [12:0] c);
    logic [12:0] f;
    logic [3:0]  s;
    logic        par;
    int          j;
    sfh_ecc_s    r;
    f = c;
    s = '0;
    j = 0;
    r = '0;
    par = ^c;
    for (int k = 0; k < 4; k++) begin
      for (int p = 1; p < 13; p++) begin
        if (p[k]) s[k] = s[k] ^ c[p];
      end
    end
    if (par && s != 4'h0 && s < 4'hD) f[s] = ~f[s];
    r.sgl = par && s < 4'hD;
    r.dbl = (s != 4'h0 && !par) || s >= 4'hD;
    for (int p = 3; p < 13; p++) begin
      if (p != 4 && p != 8) begin
        r.data[j] = f[p];
        j++;
      end
    end
    return r;
  endfunction : sfh_ecc_dec

  localparam logic [12:0] ERASED_CW = sfh_ecc_enc(ERASED_BYTE);

endpackage : sfh_pkg

// >>> tb/sfh_flash_front_sva.sv
/*
  Checker of the serial flash front end ports, bound to every instance.
  Assumes the link clock runs only inside frames, as the host model does.
*/
`timescale 1ns/1ps
`default_nettype none
module sfh_flash_front_sva (
  // System side
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       ready,
  // Link side
  input wire logic       serial_clock,
  input wire logic       cs_n,
  input wire logic       reset_n,
  input wire logic [3:0] dq_out,
  input wire logic [3:0] dq_oe_n
);
  logic [5:0] rise_q;
  logic       tog_q;
  logic [3:0] hi_q;

  // Rises in this frame; the toggle shows a rise since the last sample
  always_ff @(posedge serial_clock or posedge cs_n) begin
    if (cs_n) begin
      rise_q <= 6'h00;
      tog_q  <= 1'b0;
    end else begin
      rise_q <= (rise_q == 6'h3F) ? rise_q : rise_q + 6'h01;
      tog_q  <= ~tog_q;
    end
  end

  always_ff @(posedge serial_clock) begin
    hi_q <= dq_out;
  end

  property p_cs_off;
    @(posedge sys_clk) disable iff (sys_rst) cs_n && $past(cs_n) |-> dq_oe_n == 4'hF;
  endproperty
  a_cs_off: assert property (p_cs_off) else $error("lanes driven while deselected");

  property p_pin_off;
    @(posedge sys_clk) disable iff (sys_rst) !reset_n |-> dq_oe_n == 4'hF;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("lanes driven in pin reset");

  property p_pin_idle;
    @(posedge sys_clk) disable iff (sys_rst) (!reset_n) [*6] |-> ready;
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("engine busy in pin reset");

  property p_lane_use;
    @(posedge sys_clk) disable iff (sys_rst)
      dq_oe_n == 4'hF || dq_oe_n == 4'hD || dq_oe_n == 4'h0;
  endproperty
  a_lane_use: assert property (p_lane_use) else $error("illegal lane enable set");

  property p_cmd_first;
    @(posedge sys_clk) disable iff (sys_rst) rise_q < 6'h08 |-> dq_oe_n == 4'hF;
  endproperty
  a_cmd_first: assert property (p_cmd_first) else $error("output before command done");

  property p_fall_drive;
    @(posedge sys_clk) disable iff (sys_rst)
      !cs_n && serial_clock && rise_q != 6'h00 && $stable(tog_q) |-> dq_out == hi_q;
  endproperty
  a_fall_drive: assert property (p_fall_drive) else $error("output moved in high phase");

  property p_start_late;
    @(posedge sys_clk) disable iff (sys_rst) $fell(ready) |-> cs_n && $past(cs_n, 2);
  endproperty
  a_start_late: assert property (p_start_late) else $error("engine started in frame");

  property p_idle_hold;
    @(posedge sys_clk) disable iff (sys_rst) (cs_n && ready) [*8] |=> ready;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("engine started while idle");
endmodule : sfh_flash_front_sva

bind sfh_flash_front sfh_flash_front_sva chk_u (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .ready(ready), .serial_clock(serial_clock),
  .cs_n(cs_n), .reset_n(reset_n), .dq_out(dq_out), .dq_oe_n(dq_oe_n)
);
`default_nettype wire

// >>> tb/sfh_host_model.sv
/*
  Host controller model: chip select, link clock and lane drive.
  Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module sfh_host_model (
  // Link outputs
  output logic            serial_clock,
  output logic            cs_n,
  output logic      [3:0] dq_in,
  // Device lanes
  input  wire logic [3:0] dq_out,
  input  wire logic [3:0] dq_oe_n
);
  localparam realtime HP = 62.5;
  logic       mode3  = 1'b0;
  logic [3:0] drv    = 4'h0;
  logic [3:0] drv_en = 4'h0;

  // Released lanes show the inverse of the last value, never a stale copy
  assign dq_in = (~dq_oe_n & dq_out) | (dq_oe_n & drv_en & drv) | (dq_oe_n & ~drv_en & ~drv);

  initial begin
    serial_clock <= 1'b0;
    cs_n         <= 1'b1;
  end

  task automatic start();
    serial_clock = mode3;
    #HP;
    cs_n = 1'b0;
    #HP;
  endtask : start

  // Lanes change in the low half, device takes them at the rise
  task automatic send(input logic [31:0] v, input int n, input int w);
    for (int i = n; i > 0; i -= w) begin
      serial_clock = 1'b0;
      drv_en       = (w == 4) ? 4'hF : 4'h1;
      drv          = (w == 4) ? v[i-1 -: 4] : {3'h0, v[i-1]};
      #HP;
      serial_clock = 1'b1;
      #HP;
    end
  endtask : send

  task automatic recv(output logic [7:0] b, input int w);
    b      = 8'h00;
    drv_en = 4'h0;
    for (int i = 0; i < 8; i += w) begin
      serial_clock = 1'b0;
      #HP;
      serial_clock = 1'b1;
      b            = (w == 4) ? {b[3:0], dq_in} : {b[6:0], dq_in[1]};
      #HP;
    end
  endtask : recv

  task automatic hdr(input logic [7:0] cmd, input logic [31:0] a, input int ab, input int aw);
    start();
    send({24'h0, cmd}, 8, 1);
    if (ab > 0) send(a, ab, aw);
  endtask : hdr

  task automatic stop();
    serial_clock = mode3;
    #HP;
    drv_en = 4'h0;
    cs_n   = 1'b1;
    #200;
  endtask : stop
endmodule : sfh_host_model
`default_nettype wire

// >>> tb/serial_flash_host_interface_test.sv
/*
  Self-checking bench of the serial flash front end.
  Assumes sfh_host_model as host and the checker bound from its own file.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_flash_host_interface_test;
  import sfh_pkg::*;

  logic            sys_clk      = 1'b0;
  logic            sys_rst;
  logic            reset_n      = 1'b1;
  logic            page_512     = 1'b0;
  logic            large_sector = 1'b0;
  wire logic       serial_clock;
  wire logic       cs_n;
  wire logic       ready;
  wire logic [3:0] dq_in;
  wire logic [3:0] dq_out;
  wire logic [3:0] dq_oe_n;
  int              n_errors     = 0;
  int              num_checks   = 0;

  always #10 sys_clk = ~sys_clk;

  sfh_flash_front #(.AW(12)) dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .serial_clock(serial_clock), .cs_n(cs_n),
    .reset_n(reset_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .page_512(page_512), .large_sector(large_sector), .ready(ready)
  );

  sfh_host_model host_u (
    .serial_clock(serial_clock), .cs_n(cs_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n)
  );

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Bounded: a stuck engine ends the run
  task automatic wait_idle();
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 9000) begin
      @(posedge sys_clk);
      k++;
    end
    check("engine idle", {15'h0, ready}, 16'h0001);
    if (k == 9000) report_and_stop();
  endtask : wait_idle

  task automatic rd(input logic [7:0] cmd, input logic [31:0] a, input int ab, input int aw,
                    input int dw, input logic [15:0] exp);
    logic [7:0] b;
    host_u.hdr(cmd, a, ab, aw);
    host_u.send(32'h5A, 8, 1);
    for (int i = 0; i < 2; i++) begin
      host_u.recv(b, dw);
      check("read byte", {8'h00, b}, {8'h00, exp[15 - 8 * i -: 8]});
    end
    host_u.stop();
  endtask : rd

  task automatic wr(input logic [7:0] cmd, input logic [31:0] a, input int ab, input int aw,
                    input int dw, input logic [15:0] d, input int n);
    host_u.hdr(cmd, a, ab, aw);
    for (int i = 0; i < n; i++) host_u.send({24'h0, d[15 - 8 * i -: 8]}, 8, dw);
    host_u.stop();
  endtask : wr

  task automatic t_prog();
    wr(CMD_ERASE, 32'h0, 24, 1, 1, 16'h0, 0);
    wait_idle();
    rd(CMD_READ, 32'hFFE, 24, 1, 1, 16'hFFFF);
    wr(CMD_PROG, 32'h0FF, 24, 1, 1, 16'hA53C, 2);
    wait_idle();
    wr(CMD_PROG, 32'h0FF, 24, 1, 1, 16'h0F00, 1);
    wait_idle();
    rd(CMD_READ, 32'h0FF, 24, 1, 1, 16'h05FF);
    rd(CMD_FAST_READ, 32'h0, 24, 1, 1, 16'h3CFF);
    // Large page: no wrap at the 256-byte boundary
    @(posedge sys_clk);
    page_512 <= 1'b1;
    wr(CMD_PROG, 32'h2FF, 24, 1, 1, 16'h9966, 2);
    wait_idle();
    rd(CMD_READ, 32'h2FF, 24, 1, 1, 16'h9966);
    @(posedge sys_clk);
    page_512 <= 1'b0;
    $display("Test program done");
  endtask : t_prog

  task automatic t_quad();
    rd(CMD_QOUT_READ, 32'h0FF, 24, 1, 4, 16'h05FF);
    rd(CMD_QIO_READ, 32'h0FF, 24, 4, 4, 16'h05FF);
    wr(CMD_QPROG, 32'h040, 24, 1, 4, 16'hC300, 1);
    wait_idle();
    host_u.mode3 = 1'b1;
    rd(CMD_READ, 32'h040, 24, 1, 1, 16'hC3FF);
    host_u.mode3 = 1'b0;
    wr(CMD_EN_ADDR4, 32'h0, 0, 1, 1, 16'h0, 0);
    rd(CMD_READ, 32'h0FF, 32, 1, 1, 16'h05FF);
    rd(CMD_QIO_READ, 32'h0, 32, 4, 4, 16'h3CFF);
    wr(CMD_EX_ADDR4, 32'h0, 0, 1, 1, 16'h0, 0);
    rd(CMD_READ, 32'h040, 24, 1, 1, 16'hC3FF);
    $display("Test quad done");
  endtask : t_quad

  task automatic t_busy();
    logic [7:0] b;
    int         k;
    wr(CMD_ERASE, 32'h0, 24, 1, 1, 16'h0, 0);
    host_u.hdr(CMD_READ, 32'h040, 24, 1);
    host_u.send(32'h5A, 8, 1);
    host_u.recv(b, 1);
    check("lanes while busy", {12'h0, dq_oe_n}, 16'h000F);
    host_u.stop();
    wr(CMD_PROG, 32'h040, 24, 1, 1, 16'h0000, 1);
    wr(CMD_SUSPEND, 32'h0, 0, 1, 1, 16'h0, 0);
    host_u.hdr(CMD_RD_ST1, 32'h0, 0, 1);
    host_u.recv(b, 1);
    check("suspended status", {8'h00, b}, 16'h0003);
    host_u.stop();
    wr(CMD_RESUME, 32'h0, 0, 1, 1, 16'h0, 0);
    host_u.hdr(CMD_RD_ST1, 32'h0, 0, 1);
    host_u.recv(b, 1);
    check("busy bit", {15'h0, b[0]}, 16'h0001);
    k = 0;
    while (b[0] === 1'b1 && k < 200) begin
      host_u.recv(b, 1);
      k++;
    end
    check("busy bit cleared", {15'h0, b[0]}, 16'h0000);
    if (k == 200) report_and_stop();
    host_u.stop();
    wait_idle();
    rd(CMD_READ, 32'h040, 24, 1, 1, 16'hFFFF);
    host_u.hdr(CMD_RD_ST2, 32'h0, 0, 1);
    host_u.recv(b, 1);
    check("ECC status", {8'h00, b}, 16'h0000);
    host_u.stop();
    $display("Test busy done");
  endtask : t_busy

  task automatic t_pin_reset();
    wr(CMD_ERASE, 32'h0, 24, 1, 1, 16'h0, 0);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    check("ready in pin reset", {15'h0, ready}, 16'h0001);
    check("lanes in pin reset", {12'h0, dq_oe_n}, 16'h000F);
    @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    // Erase header still held: a cut frame must not rerun it
    host_u.start();
    host_u.send({28'h0, CMD_ERASE[7:4]}, 4, 1);
    host_u.stop();
    @(negedge sys_clk);
    check("ready after short frame", {15'h0, ready}, 16'h0001);
    $display("Test pin reset done");
  endtask : t_pin_reset

  initial begin
    // A real edge, so the link-side async resets fire
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(negedge sys_clk);
    check("ready after reset", {15'h0, ready}, 16'h0001);
    check("lanes after reset", {12'h0, dq_oe_n}, 16'h000F);
    t_prog();
    t_quad();
    t_busy();
    t_pin_reset();
    report_and_stop();
  end
endmodule : serial_flash_host_interface_test
`default_nettype wire
